// >>> rtl/ssd_cfg.svh
`ifndef SSD_CFG_SVH
`define SSD_CFG_SVH
// response byte bit positions
`define SSD_RSP_OUT_EN     0
`define SSD_RSP_ACT_ID     1
`define SSD_RSP_INPUTS     4
`define SSD_RSP_LIMIT      5
`define SSD_RSP_WARN       6
`define SSD_RSP_ERR        7
// detail byte bit positions (same layout for warning and error)
`define SSD_DET_OUT_A      0
`define SSD_DET_OUT_B      1
`define SSD_DET_XWIRE      2
`define SSD_DET_TEMP       3
`define SSD_DET_ACTUATOR   4
`define SSD_DET_INTERNAL   5
`define SSD_DET_SPARE      6
`define SSD_DET_COMM       7
// request byte: fault reset bit
`define SSD_REQ_RESET      7
`define SSD_BYTE_ZERO      8'h00
// cause bits 0..5 of a detail byte
`define SSD_CAUSE_MASK     8'h3f
// latched error byte holding only the comm failure bit
`define SSD_ERR_COMM_ONLY  8'h80
`endif

// >>> rtl/ssd_pkg.sv
package ssd_pkg;
  typedef logic [7:0] ssd_byte_t;
  typedef enum logic [1:0] {
    SSD_OK,
    SSD_WARN,
    SSD_FAULT
  } ssd_state_t;
endpackage

// >>> rtl/ssd_fault_latch.sv
`timescale 1ns/1ps
`include "ssd_cfg.svh"
// holds latched error causes until cause gone and reset event seen
module ssd_fault_latch
  import ssd_pkg::*;
(
  input  wire logic      clk_sys_in,
  input  wire logic      srst_in,
  input  wire ssd_byte_t cause_in,
  input  wire logic      clear_in,
  output ssd_byte_t      held_out
);
  ssd_byte_t held_reg;
  ssd_byte_t held_next;

  // set wins over clear: a live cause always stays latched
  always_comb begin
    held_next = held_reg | cause_in;
    if (clear_in) begin
      held_next = cause_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      held_reg <= `SSD_BYTE_ZERO;
    end else begin
      held_reg <= held_next;
    end
  end

  assign held_out = held_reg;
endmodule

// >>> rtl/ssd_diag.sv
`timescale 1ns/1ps
`include "ssd_cfg.svh"
module ssd_diag
  import ssd_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       srst_in,
  input  wire logic       safety_in_a_in,
  input  wire logic       safety_in_b_in,
  input  wire logic       actuator_ok_in,
  input  wire logic       actuator_limit_in,
  input  wire logic       outputs_on_in,
  input  wire ssd_byte_t  warn_cause_in,
  input  wire ssd_byte_t  err_cause_in,
  input  wire logic       comm_fail_in,
  input  wire logic       guard_open_in,
  input  wire ssd_byte_t  request_byte_in,
  input  wire logic       request_valid_in,
  output logic            safety_out_a_out,
  output logic            safety_out_b_out,
  output ssd_byte_t       response_byte_out,
  output ssd_byte_t       warning_detail_byte_out,
  output ssd_byte_t       error_detail_byte_out
);
  ssd_byte_t  rsp_reg;
  ssd_byte_t  rsp_next;
  ssd_byte_t  warn_reg;
  ssd_byte_t  warn_next;
  ssd_byte_t  err_reg;
  ssd_byte_t  err_next;
  logic       req7_reg;
  logic       req7_next;
  logic       out_a_reg;
  logic       out_a_next;
  logic       out_b_reg;
  logic       out_b_next;
  ssd_state_t st_reg;
  ssd_state_t st_next;
  ssd_byte_t  err_live;
  ssd_byte_t  err_held;
  logic       clear_evt;

  // reset event: request bit 7 going 1 to 0, or guard opened
  assign clear_evt = (request_valid_in && req7_reg && !request_byte_in[`SSD_REQ_RESET])
                   || guard_open_in;

  // error causes; comm failure gets its own bit
  always_comb begin
    err_live = err_cause_in;
    err_live[`SSD_DET_COMM] = comm_fail_in;
    err_live[`SSD_DET_SPARE] = 1'b0;
  end

  // latched error causes; a live cause always survives a clear in the same cycle
  ssd_fault_latch u_latch (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .cause_in   (err_live),
    .clear_in   (clear_evt),
    .held_out   (err_held)
  );

  // next state of bytes and outputs; enable and limit bits follow the next outputs
  always_comb begin
    req7_next = request_valid_in ? request_byte_in[`SSD_REQ_RESET] : req7_reg;
    warn_next = warn_cause_in & `SSD_CAUSE_MASK;
    err_next  = err_held;
    // a comm failure alone is no fault, otherwise the outputs would drop for it
    if (err_held != `SSD_BYTE_ZERO && err_held != `SSD_ERR_COMM_ONLY) begin
      st_next = SSD_FAULT;
    end else if (warn_next != `SSD_BYTE_ZERO) begin
      st_next = SSD_WARN;
    end else begin
      st_next = SSD_OK;
    end
    // comm failure alone holds outputs where they were
    if (comm_fail_in && st_next != SSD_FAULT) begin
      out_a_next = out_a_reg;
      out_b_next = out_b_reg;
    end else begin
      out_a_next = outputs_on_in && (st_next != SSD_FAULT);
      out_b_next = outputs_on_in && (st_next != SSD_FAULT);
    end
    rsp_next = `SSD_BYTE_ZERO;
    rsp_next[`SSD_RSP_OUT_EN] = out_a_next && out_b_next;
    rsp_next[`SSD_RSP_ACT_ID] = actuator_ok_in;
    rsp_next[`SSD_RSP_INPUTS] = safety_in_a_in && safety_in_b_in;
    rsp_next[`SSD_RSP_LIMIT]  = actuator_limit_in && out_a_next && out_b_next;
    rsp_next[`SSD_RSP_WARN]   = (st_next != SSD_OK);
    rsp_next[`SSD_RSP_ERR]    = (st_next == SSD_FAULT);
  end

  // registers only; outputs come straight from these
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rsp_reg   <= `SSD_BYTE_ZERO;
      warn_reg  <= `SSD_BYTE_ZERO;
      err_reg   <= `SSD_BYTE_ZERO;
      req7_reg  <= 1'b0;
      out_a_reg <= 1'b0;
      out_b_reg <= 1'b0;
      st_reg    <= SSD_OK;
    end else begin
      rsp_reg   <= rsp_next;
      warn_reg  <= warn_next;
      err_reg   <= err_next;
      req7_reg  <= req7_next;
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
      st_reg    <= st_next;
    end
  end

  assign response_byte_out       = rsp_reg;
  assign warning_detail_byte_out = warn_reg;
  assign error_detail_byte_out   = err_reg;
  assign safety_out_a_out        = out_a_reg;
  assign safety_out_b_out        = out_b_reg;

  // input and actuator bits one cycle after their inputs; limit, error and state bits against outputs same cycle; comm detail bit two cycles on
  property p_inputs;
    @(posedge clk_sys_in) disable iff (srst_in)
      1 |=> rsp_reg[`SSD_RSP_INPUTS] == $past(safety_in_a_in && safety_in_b_in);
  endproperty
  a_inputs: assert property (p_inputs) else $error("input bit wrong");

  property p_act;
    @(posedge clk_sys_in) disable iff (srst_in)
      1 |=> rsp_reg[`SSD_RSP_ACT_ID] == $past(actuator_ok_in);
  endproperty
  a_act: assert property (p_act) else $error("actuator bit wrong");

  property p_limit;
    @(posedge clk_sys_in) disable iff (srst_in)
      rsp_reg[`SSD_RSP_LIMIT] |-> rsp_reg[`SSD_RSP_OUT_EN];
  endproperty
  a_limit: assert property (p_limit) else $error("limit bit without outputs");

  property p_comm;
    @(posedge clk_sys_in) disable iff (srst_in)
      comm_fail_in |=> ##1 err_reg[`SSD_DET_COMM];
  endproperty
  a_comm: assert property (p_comm) else $error("comm bit missing");

  property p_err_off;
    @(posedge clk_sys_in) disable iff (srst_in)
      rsp_reg[`SSD_RSP_ERR]
        |-> !safety_out_a_out && !safety_out_b_out && rsp_reg[`SSD_RSP_WARN];
  endproperty
  a_err_off: assert property (p_err_off) else $error("error with outputs on");

  property p_state;
    @(posedge clk_sys_in) disable iff (srst_in)
      (st_reg == SSD_FAULT) |-> rsp_reg[`SSD_RSP_ERR] && !safety_out_a_out;
  endproperty
  a_state: assert property (p_state) else $error("fault state not shown");

  // outputs: comm loss without a fault must not move them, and both channels switch together
  property p_hold;
    @(posedge clk_sys_in) disable iff (srst_in)
      (comm_fail_in && st_next != SSD_FAULT)
        |=> $stable(safety_out_a_out) && $stable(safety_out_b_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved on comm fail");

  property p_pair;
    @(posedge clk_sys_in) disable iff (srst_in)
      safety_out_a_out == safety_out_b_out;
  endproperty
  a_pair: assert property (p_pair) else $error("output channels differ");

  property p_detail;
    @(posedge clk_sys_in) disable iff (srst_in)
      (rsp_reg[`SSD_RSP_WARN] && !rsp_reg[`SSD_RSP_ERR])
        |-> warning_detail_byte_out != `SSD_BYTE_ZERO;
  endproperty
  a_detail: assert property (p_detail) else $error("warning without detail");

  property p_err_detail;
    @(posedge clk_sys_in) disable iff (srst_in)
      rsp_reg[`SSD_RSP_ERR]
        |-> (error_detail_byte_out & `SSD_CAUSE_MASK) != `SSD_BYTE_ZERO;
  endproperty
  a_err_detail: assert property (p_err_detail) else $error("error without detail");

  // latch: set always lands, clear keeps only live causes, out A bit drops only on a clear
  property p_latch;
    @(posedge clk_sys_in) disable iff (srst_in)
      (err_held[`SSD_DET_OUT_A] && !clear_evt) |=> err_held[`SSD_DET_OUT_A];
  endproperty
  a_latch: assert property (p_latch) else $error("fault dropped without reset");

  property p_set;
    @(posedge clk_sys_in) disable iff (srst_in)
      (err_live != `SSD_BYTE_ZERO)
        |=> (err_held & $past(err_live)) == $past(err_live);
  endproperty
  a_set: assert property (p_set) else $error("live cause not latched");

  property p_clear;
    @(posedge clk_sys_in) disable iff (srst_in)
      clear_evt |=> err_held == $past(err_live);
  endproperty
  a_clear: assert property (p_clear) else $error("clear kept a gone cause");

  property p_out_en;
    @(posedge clk_sys_in) disable iff (srst_in)
      rsp_reg[`SSD_RSP_OUT_EN] == (safety_out_a_out && safety_out_b_out);
  endproperty
  a_out_en: assert property (p_out_en) else $error("enable bit mismatch");

  // main scenarios that the bench is meant to reach
  c_fault: cover property (@(posedge clk_sys_in) rsp_reg[`SSD_RSP_ERR]);
  c_warn:  cover property (@(posedge clk_sys_in) rsp_reg[`SSD_RSP_WARN] && !rsp_reg[`SSD_RSP_ERR]);
  c_limit: cover property (@(posedge clk_sys_in) rsp_reg[`SSD_RSP_LIMIT]);
  c_clear: cover property (@(posedge clk_sys_in)
                           err_reg[`SSD_DET_OUT_A] ##1 !err_reg[`SSD_DET_OUT_A]);
  c_hold:  cover property (@(posedge clk_sys_in) comm_fail_in && safety_out_a_out);
endmodule

// >>> test/ssd_gw_model.sv
`timescale 1ns/1ps
// gateway side: sends request bytes toward the sensor, never reads them back
module ssd_gw_model (
  input  wire logic  clk_sys_in,
  output logic [7:0] request_byte_out,
  output logic       request_valid_out
);
  initial begin
    request_byte_out  = 8'h00;
    request_valid_out = 1'b0;
  end
  // one valid cycle; the idle line shows the inverse so stale data is never mistaken
  task automatic send(input logic [7:0] b);
    @(posedge clk_sys_in);
    request_byte_out  <= b;
    request_valid_out <= 1'b1;
    @(posedge clk_sys_in);
    request_byte_out  <= ~b;
    request_valid_out <= 1'b0;
  endtask
endmodule

// >>> test/safety_sensor_serial_diag_bench.sv
`timescale 1ns/1ps
module safety_sensor_serial_diag_bench;
  import ssd_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        srst_in    = 1'b1;
  logic [22:0] s          = 23'h0;
  logic [7:0]  lat        = 8'h00;
  logic        o          = 1'b0;
  logic        e;
  logic        req_v, out_a, out_b;
  ssd_byte_t   req, rsp, wdet, edet;
  logic [31:0] exp_q[$];
  logic [31:0] note;
  int          errors     = 0;
  int          compares   = 0;
  int          cyc        = 0;
  int          seed;
  always #2 clk_sys_in = ~clk_sys_in;
  ssd_gw_model gw (.clk_sys_in(clk_sys_in), .request_byte_out(req), .request_valid_out(req_v));
  ssd_diag uut (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .safety_in_a_in(s[22]),
    .safety_in_b_in(s[21]), .actuator_ok_in(s[20]), .actuator_limit_in(s[19]),
    .outputs_on_in(s[18]), .comm_fail_in(s[17]), .guard_open_in(s[16]),
    .warn_cause_in(s[15:8]), .err_cause_in(s[7:0]), .request_byte_in(req),
    .request_valid_in(req_v), .safety_out_a_out(out_a), .safety_out_b_out(out_b),
    .response_byte_out(rsp), .warning_detail_byte_out(wdet), .error_detail_byte_out(edet));
  task automatic cmp(input string n, input ssd_byte_t x, input ssd_byte_t g);
    compares++;
    if (g !== x) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  // drive one input set, let it settle, then note what the outputs must show
  task automatic apply(input logic [22:0] v);
    @(posedge clk_sys_in);
    s <= v;
    repeat (4) @(posedge clk_sys_in);
    lat = lat | {v[17], 1'b0, v[5:0]};
    if (v[16]) lat = {v[17], 1'b0, v[5:0]};
    e = |lat[5:0];
    if (e) o = 1'b0; // a latched fault drops the outputs even with comm lost
    else if (!v[17]) o = v[18]; // comm loss alone keeps the old output state
    exp_q.push_back({6'h0, o, o, e, (|v[13:8]) | e, v[19] & o, v[22] & v[21], 2'b00, v[20], o,
                     2'b00, v[13:8], lat});
  endtask
  // watcher on the falling edge: outputs have settled and no race with the note
  always @(negedge clk_sys_in) begin
    if (exp_q.size() > 0) begin
      note = exp_q.pop_front();
      cmp("outputs", note[31:24], {6'h0, out_a, out_b});
      cmp("response", note[23:16], rsp);
      cmp("warning", note[15:8], wdet);
      cmp("error", note[7:0], edet);
    end
  end
  task automatic results;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      results();
    end
  end
  initial begin
    seed = $urandom(32'h65908205);
    repeat (3) @(posedge clk_sys_in);
    exp_q.push_back(32'h0); // outputs all clear while in reset
    @(posedge clk_sys_in);
    srst_in <= 1'b0;
    apply(23'h740000);
    apply(23'h7c0000);
    apply(23'h740800);
    for (int k = 0; k < 6; k++) begin
      apply(23'h740000 | (23'h1 << k));
      apply(23'h740000);
      if (k[0]) apply(23'h750000);
      else begin
        gw.send(8'h80);
        gw.send(8'h00);
        lat = 8'h00;
      end
      apply(23'h740000);
    end
    apply(23'h760000);
    apply(23'h720000);
    apply(23'h760001);
    apply(23'h710000);
    // random mixes of conditions, no errors, so the latch stays empty
    repeat (24) apply(23'($urandom) & 23'h7cff00);
    repeat (3) @(posedge clk_sys_in);
    results();
  end
endmodule
